// ---- hdl/vdpc_pkg.sv ----
// package: cycle kinds, pin bundles and timing constants for the video dram port controller
package vdpc_pkg;
    localparam int ROW_W = 9;
    localparam int COL_W = 9;
    localparam int DATA_W = 8;
    localparam int ROW_COUNT = 512;
    // refresh interval in ns and per-row spacing in clock cycles
    localparam real REFRESH_INTERVAL_NS = 16.7e6;
    localparam real CLK_PERIOD_NS = 25.0;
    localparam int REFRESH_SPACING_CYC = int'($floor(REFRESH_INTERVAL_NS / ROW_COUNT / CLK_PERIOD_NS));
    // last phase count of a strobe step (each pin step holds PHASE_CYC + 1 = 3 clock cycles)
    localparam logic [3:0] PHASE_CYC = 4'h2;
    localparam logic [3:0] PHASE_RESET = 4'h0;
    localparam logic [15:0] REFRESH_CNT_RESET = 16'h0000;

    typedef enum logic [2:0] {
        VDPC_CMD_READ = 3'b000,
        VDPC_CMD_WRITE = 3'b001,
        VDPC_CMD_MASKED_WRITE = 3'b010,
        VDPC_CMD_READ_XFER = 3'b011,
        VDPC_CMD_WRITE_XFER = 3'b100,
        VDPC_CMD_RAS_REFRESH = 3'b101,
        VDPC_CMD_CBR_REFRESH = 3'b110
    } vdpc_cmd_t;

    typedef enum logic [1:0] {
        VDPC_CBR_NO_RESET = 2'b00,
        VDPC_CBR_RESET_STOP_ADDRESS = 2'b01,
        VDPC_CBR_RESET_ALL = 2'b10
    } vdpc_cbr_t;

    // user request bundle
    typedef struct packed {
        vdpc_cmd_t cmd;
        vdpc_cbr_t cbr;
        logic late_write;
        logic block_write;
        logic split;
        logic [ROW_W-1:0] row;
        logic [COL_W-1:0] col;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] mask;
    } vdpc_req_t;

    // random port pin bundle driven toward the memory
    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic transfer_output_enable;
        logic mask_write_enable;
        logic special_function_select;
        logic serial_port_enable_n;
        logic [ROW_W-1:0] multiplexed_address;
    } vdpc_pins_t;
endpackage : vdpc_pkg

// ---- hdl/vdpc_ctrl.sv ----
// module: host controller that sequences the random port of a dual-port video dram
`timescale 1ns/10ps
`default_nettype none

// Operation
// (RULE1) tr low at ras fall starts transfer
// (RULE2) device drives data only when oe low
// (RULE3) mask enable low at ras fall: masked
// (RULE4) write enable high reads, low writes
// (RULE5) serial enable gates serial buffers only
// (RULE6) nine row then nine column bits latched
// (RULE7) dsf at cas fall picks block write
// (RULE8) transfer: row at ras, tap at cas
// (RULE9) split flag shows serial buffer half
// (RULE10) all 512 rows refreshed every 16.7ms
// (RULE11) cbr refresh uses internal row counter
// (RULE12) three cbr variants chosen by we, dsf
// (RULE13) ras-only refresh needs host row address
// (RULE14) ras toggle with cas low hides refresh
// (RULE15) every access also refreshes its row
// (RULE16) tr high at ras fall for accesses
// (RULE17) read: we high, oe low after ras
// (RULE18) we high at ras fall unless masked
// (RULE19) we low before cas: early write
// (RULE20) nothing starts while ras stays high
// (RULE21) read data held while ras, oe low
// (RULE22) outputs off after later strobe rise
// (RULE23) dsf low cbr resets all modes
// (RULE24) dsf high at cas fall: block write
// (RULE25) no device drive during write cycles
module vdpc_ctrl (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    output logic req_ready,
    input wire vdpc_pkg::vdpc_req_t req,
    output logic rdata_valid,
    output logic [vdpc_pkg::DATA_W-1:0] rdata,
    output logic refresh_due,
    input wire logic serial_enable_req,
    output vdpc_pkg::vdpc_pins_t pins,
    input wire logic [vdpc_pkg::DATA_W-1:0] random_data_in,
    output logic [vdpc_pkg::DATA_W-1:0] random_data_out,
    output logic random_data_oe,
    input wire logic split_half_flag,
    output logic split_half
);
    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        VDPC_IDLE = 4'b0000,
        VDPC_SETUP = 4'b0001,
        VDPC_RAS = 4'b0010,
        VDPC_CAS = 4'b0011,
        VDPC_LATE_WE = 4'b0100,
        VDPC_SAMPLE = 4'b0101,
        VDPC_RELEASE = 4'b0110,
        VDPC_PRECHARGE = 4'b0111,
        VDPC_CBR_CAS = 4'b1000,
        VDPC_CBR_RAS = 4'b1001
    } vdpc_state_t;

    vdpc_state_t state;
    vdpc_state_t next_state;
    vdpc_pkg::vdpc_req_t cur;
    logic [3:0] phase;
    logic phase_done;
    logic [15:0] refresh_cnt;

    // decode: cycles where the host drives the data pins
    function automatic logic is_write(input vdpc_pkg::vdpc_cmd_t c);
        is_write = (c == vdpc_pkg::VDPC_CMD_WRITE) || (c == vdpc_pkg::VDPC_CMD_MASKED_WRITE);
    endfunction : is_write

    // decode: transfer cycles
    function automatic logic is_xfer(input vdpc_pkg::vdpc_cmd_t c);
        is_xfer = (c == vdpc_pkg::VDPC_CMD_READ_XFER) || (c == vdpc_pkg::VDPC_CMD_WRITE_XFER);
    endfunction : is_xfer

    assign phase_done = (phase == vdpc_pkg::PHASE_CYC);
    assign req_ready = (state == VDPC_IDLE);

    // ------------------------------------------------------------
    // phase timer and state register
    // ------------------------------------------------------------
    // each pin step holds for a fixed number of cycles
    always_ff @(posedge clk) begin
        if (srst || phase_done || state == VDPC_IDLE) begin
            phase <= vdpc_pkg::PHASE_RESET;
        end else begin
            phase <= phase + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= VDPC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // request capture
    always_ff @(posedge clk) begin
        if (srst) begin
            cur <= '0;
        end else if (req_valid && req_ready) begin
            cur <= req;
        end
    end

    // next state
    always_comb begin
        next_state = state;
        unique case (state)
            VDPC_IDLE: begin
                if (req_valid) begin
                    next_state = VDPC_SETUP;
                end
            end
            VDPC_SETUP: begin
                if (phase_done) begin
                    // cas before ras for refresh without address
                    next_state = (cur.cmd == vdpc_pkg::VDPC_CMD_CBR_REFRESH) ?
                        VDPC_CBR_CAS : VDPC_RAS; // RULE11
                end
            end
            VDPC_RAS: begin
                if (phase_done) begin
                    next_state = (cur.cmd == vdpc_pkg::VDPC_CMD_RAS_REFRESH) ?
                        VDPC_RELEASE : VDPC_CAS; // RULE13
                end
            end
            VDPC_CAS: begin
                if (phase_done) begin
                    next_state = (is_write(cur.cmd) && cur.late_write) ?
                        VDPC_LATE_WE : VDPC_SAMPLE; // RULE19
                end
            end
            // fixed-length steps simply advance when their phase ends
            VDPC_LATE_WE: if (phase_done) next_state = VDPC_SAMPLE;
            VDPC_SAMPLE: if (phase_done) next_state = VDPC_RELEASE;
            VDPC_CBR_CAS: if (phase_done) next_state = VDPC_CBR_RAS;
            VDPC_CBR_RAS: if (phase_done) next_state = VDPC_RELEASE;
            VDPC_RELEASE: if (phase_done) next_state = VDPC_PRECHARGE;
            VDPC_PRECHARGE: if (phase_done) next_state = VDPC_IDLE;
            default: next_state = VDPC_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // strobes and control levels are registered per state
    always_ff @(posedge clk) begin
        if (srst) begin
            pins <= '{ras_n: 1'b1, cas_n: 1'b1, transfer_output_enable: 1'b1,
                       mask_write_enable: 1'b1, special_function_select: 1'b0,
                       serial_port_enable_n: 1'b1, multiplexed_address: '0};
        end else begin
            pins.serial_port_enable_n <= ~serial_enable_req; // RULE5
            unique case (next_state)
                VDPC_SETUP: begin
                    pins.ras_n <= 1'b1;
                    pins.cas_n <= 1'b1;
                    pins.multiplexed_address <= cur.row; // RULE6 RULE13
                    pins.transfer_output_enable <= ~is_xfer(cur.cmd); // RULE1 RULE16
                    pins.mask_write_enable <= ~((cur.cmd == vdpc_pkg::VDPC_CMD_MASKED_WRITE) ||
                        (cur.cmd == vdpc_pkg::VDPC_CMD_WRITE_XFER)); // RULE3 RULE4 RULE18
                    pins.special_function_select <= cur.split && is_xfer(cur.cmd);
                end
                VDPC_RAS: begin
                    pins.ras_n <= 1'b0; // RULE20
                    // column, block select and early we settle after the row fall, before cas
                    if (state == VDPC_RAS) begin
                        pins.multiplexed_address <= cur.col; // RULE6 RULE8
                        pins.special_function_select <=
                            cur.block_write && is_write(cur.cmd); // RULE24 RULE7
                        pins.mask_write_enable <=
                            !(is_write(cur.cmd) && !cur.late_write); // RULE19 RULE17
                    end
                end
                VDPC_CAS: begin
                    pins.cas_n <= 1'b0;
                end
                VDPC_LATE_WE: begin
                    pins.mask_write_enable <= 1'b0; // RULE19
                end
                VDPC_SAMPLE: begin
                    // read output enable only after ras fell
                    pins.transfer_output_enable <= is_write(cur.cmd) || is_xfer(cur.cmd); // RULE17 RULE2 RULE25
                end
                VDPC_CBR_CAS: begin
                    pins.cas_n <= 1'b0;
                    pins.mask_write_enable <= (cur.cbr != vdpc_pkg::VDPC_CBR_RESET_STOP_ADDRESS); // RULE12
                    pins.special_function_select <= (cur.cbr != vdpc_pkg::VDPC_CBR_RESET_ALL); // RULE23
                end
                VDPC_CBR_RAS: begin
                    pins.ras_n <= 1'b0; // RULE14
                end
                VDPC_RELEASE: begin
                    pins.ras_n <= 1'b1;
                    pins.cas_n <= 1'b1;
                    pins.transfer_output_enable <= 1'b1; // RULE22
                    pins.mask_write_enable <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // write data drive and host data drive enable
    always_ff @(posedge clk) begin
        if (srst) begin
            random_data_out <= '0;
            random_data_oe <= 1'b0;
        end else begin
            // mask set up during setup and held across the row strobe fall
            random_data_out <= (state == VDPC_SETUP &&
                cur.cmd == vdpc_pkg::VDPC_CMD_MASKED_WRITE) ? cur.mask : cur.wdata; // RULE3
            random_data_oe <= is_write(cur.cmd) && (state == VDPC_SETUP ||
                next_state == VDPC_RAS || next_state == VDPC_CAS ||
                next_state == VDPC_LATE_WE || next_state == VDPC_SAMPLE); // RULE25
        end
    end

    // data sampled at end of oe window while ras still low
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= '0;
            rdata_valid <= 1'b0;
        end else begin
            rdata_valid <= 1'b0;
            if (state == VDPC_SAMPLE && phase_done && cur.cmd == vdpc_pkg::VDPC_CMD_READ) begin
                rdata <= random_data_in; // RULE21
                rdata_valid <= 1'b1;
            end
        end
    end

    // split flag follows the device pin
    always_ff @(posedge clk) begin
        if (srst) begin
            split_half <= 1'b0;
        end else begin
            split_half <= split_half_flag; // RULE9
        end
    end

    // per-row refresh spacing; any access also refreshes a row
    always_ff @(posedge clk) begin
        if (srst) begin
            refresh_cnt <= vdpc_pkg::REFRESH_CNT_RESET;
            refresh_due <= 1'b0;
        end else if (state == VDPC_RELEASE && phase_done) begin
            refresh_cnt <= vdpc_pkg::REFRESH_CNT_RESET; // RULE15
            refresh_due <= 1'b0;
        end else if (refresh_cnt == 16'(vdpc_pkg::REFRESH_SPACING_CYC)) begin
            refresh_due <= 1'b1; // RULE10
        end else begin
            refresh_cnt <= refresh_cnt + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_xfer_tr_low: assert property (@(posedge clk) disable iff (srst) // RULE1
        $fell(pins.ras_n) && is_xfer(cur.cmd) && state != VDPC_CBR_RAS |-> !pins.transfer_output_enable)
        else $error("transfer without tr low at ras fall");
    a_access_tr_high: assert property (@(posedge clk) disable iff (srst) // RULE16
        $fell(pins.ras_n) && !is_xfer(cur.cmd) && state == VDPC_RAS |-> pins.transfer_output_enable)
        else $error("access with tr low at ras fall");
    a_oe_after_ras: assert property (@(posedge clk) disable iff (srst) // RULE17
        $fell(pins.transfer_output_enable) && state != VDPC_SETUP |-> !pins.ras_n && !pins.cas_n)
        else $error("output enable before strobes");
    a_unmasked_we_high: assert property (@(posedge clk) disable iff (srst) // RULE18
        $fell(pins.ras_n) && state == VDPC_RAS && cur.cmd == vdpc_pkg::VDPC_CMD_WRITE
        |-> pins.mask_write_enable)
        else $error("unmasked write with we low at ras fall");
    a_no_drive_read: assert property (@(posedge clk) disable iff (srst) // RULE25
        !pins.transfer_output_enable && !pins.ras_n |-> !random_data_oe)
        else $error("host drives data while device output enabled");
    a_cbr_order: assert property (@(posedge clk) disable iff (srst) // RULE11
        $fell(pins.ras_n) && state == VDPC_CBR_RAS |-> !pins.cas_n)
        else $error("cbr without cas low first");
    a_refresh_done: assert property (@(posedge clk) disable iff (srst) // RULE10
        state == VDPC_RELEASE && phase_done |=> refresh_cnt == 16'h0000)
        else $error("refresh spacing not restarted");
    a_release_off: assert property (@(posedge clk) disable iff (srst) // RULE22
        state == VDPC_RELEASE |-> ##1 (pins.ras_n && pins.transfer_output_enable) [*2])
        else $error("strobes not released");
endmodule : vdpc_ctrl
`default_nettype wire

// ---- bench/vdpc_vram_model.sv ----
// behavioural random port of the video dram that the controller drives
`timescale 1ns/10ps
`default_nettype none
module vdpc_vram_model (
    input wire vdpc_pkg::vdpc_pins_t pins,
    input wire logic [7:0] host_data,
    input wire logic host_oe,
    output logic [7:0] dq,
    output logic split_half_flag
);
    logic [7:0] mem [logic [17:0]];
    logic [8:0] row = 9'h000;
    logic [8:0] col = 9'h000;
    logic [8:0] refresh_row = 9'h000;
    logic [7:0] mask = 8'h00;
    logic xfer = 1'b0;
    logic masked = 1'b0;
    logic cbr = 1'b0;
    logic rd_ok = 1'b0;
    logic split_seen = 1'b0;
    logic [1:0] cbr_kind = 2'h0;
    logic drive;
    int cbr_count = 0;
    int clash_count = 0;
    // ------------------------------------------------
    // array access
    // ------------------------------------------------
    function automatic logic [7:0] peek(input logic [17:0] a);
        return mem.exists(a) ? mem[a] : 8'h00;
    endfunction : peek
    // write lands at the later of column strobe and write enable fall
    task automatic store();
        if (!pins.ras_n && !pins.cas_n && !pins.mask_write_enable && !xfer && !cbr &&
            !pins.special_function_select) begin
            mem[{row, col}] = masked ? (peek({row, col}) & ~mask) | (host_data & mask)
                                     : host_data;
        end
    endtask : store
    // ------------------------------------------------
    // strobe decode
    // ------------------------------------------------
    // refresh, transfer and masked kinds are fixed at the row strobe fall; read at the cas fall, write at the later of cas and we fall
    always @(negedge pins.ras_n) begin
        cbr = !pins.cas_n;
        row = pins.multiplexed_address;
        xfer = !cbr && !pins.transfer_output_enable;
        masked = !cbr && !xfer && !pins.mask_write_enable;
        split_seen = xfer && pins.special_function_select;
        rd_ok = 1'b0;
        if (masked) mask = host_data;
        if (cbr) begin
            refresh_row = refresh_row + 9'h001;
            cbr_kind = !pins.special_function_select ? 2'h2 : {1'b0, !pins.mask_write_enable};
            cbr_count++;
        end
    end
    // column latch, serial tap and early write
    always @(negedge pins.cas_n) begin
        if (!pins.ras_n) begin
            col = pins.multiplexed_address;
            rd_ok = !xfer && !cbr && pins.mask_write_enable;
            if (xfer) split_half_flag = col[8];
        end
        store();
    end
    // late write
    always @(negedge pins.mask_write_enable) store();
    // outputs only while a read holds row strobe and output enable low
    assign drive = rd_ok && !pins.ras_n && !pins.transfer_output_enable &&
                   pins.mask_write_enable;
    // released bus shows the inverse pattern
    assign dq = host_oe ? host_data : drive ? peek({row, col}) : ~peek({row, col});
    always @(host_oe or drive) if (host_oe && drive) clash_count++;
    initial split_half_flag = 1'b0;
endmodule : vdpc_vram_model
`default_nettype wire

// ---- bench/vdpc_ctrl_tb.sv ----
// self-checking bench for the video dram port controller
`timescale 1ns/10ps
`default_nettype none
module vdpc_ctrl_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic req_valid = 1'b0;
    logic serial_enable_req = 1'b0;
    vdpc_pkg::vdpc_req_t req = '0;
    vdpc_pkg::vdpc_pins_t pins;
    logic req_ready, rdata_valid, refresh_due, random_data_oe, split_half, split_half_flag;
    logic [7:0] rdata, random_data_in, random_data_out, got;
    logic [8:0] rows [4] = '{9'h1FF, 9'h000, 9'h0AB, 9'h155};
    logic [8:0] cols [4] = '{9'h000, 9'h1FF, 9'h12C, 9'h0D3};
    logic [7:0] datas [4] = '{8'h5A, 8'hC3, 8'h96, 8'h0F};
    int err_total = 0;
    int cmp_count = 0;
    int n0;
    always #12.5 clk = ~clk;
    vdpc_ctrl uut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rdata_valid(rdata_valid), .rdata(rdata), .refresh_due(refresh_due),
        .serial_enable_req(serial_enable_req), .pins(pins), .random_data_in(random_data_in),
        .random_data_out(random_data_out), .random_data_oe(random_data_oe),
        .split_half_flag(split_half_flag), .split_half(split_half));
    vdpc_vram_model model (.pins(pins), .host_data(random_data_out), .host_oe(random_data_oe),
        .dq(random_data_in), .split_half_flag(split_half_flag));
    // ------------------------------------------------
    // access tasks
    // ------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // one request, held until taken, then wait for idle and catch read data
    task automatic run(input vdpc_pkg::vdpc_cmd_t c, input logic lw, input logic [8:0] r,
        input logic [8:0] cl, input logic [7:0] d, input logic [7:0] m,
        input vdpc_pkg::vdpc_cbr_t cb = vdpc_pkg::VDPC_CBR_NO_RESET, input logic bw = 1'b0,
        input logic sp = 1'b0);
        int n;
        n = 0;
        got = 8'hxx;
        req <= '{cmd: c, cbr: cb, late_write: lw, block_write: bw, split: sp, row: r,
                 col: cl, wdata: d, mask: m};
        req_valid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (req_ready !== 1'b1 && n < 300);
        req_valid <= 1'b0;
        do begin
            @(posedge clk);
            n++;
            if (rdata_valid === 1'b1) got = rdata;
        end while (req_ready !== 1'b1 && n < 300);
        if (n >= 300) err_total++;
    endtask : run
    // ------------------------------------------------
    // watchdog
    // ------------------------------------------------
    initial begin
        #(25 * 40000);
        err_total++;
        finish_test();
    end
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check("row strobe idle", pins.ras_n, 1'b1);
        for (int i = 0; i < 4; i++) begin
            run(vdpc_pkg::VDPC_CMD_WRITE, i[0], rows[i], cols[i], datas[i], 8'hFF);
        end
        for (int i = 0; i < 4; i++) begin
            run(vdpc_pkg::VDPC_CMD_READ, 1'b0, rows[i], cols[i], 8'h00, 8'h00);
            check("read data", got, datas[i]);
        end
        run(vdpc_pkg::VDPC_CMD_MASKED_WRITE, 1'b0, rows[2], cols[2], 8'hC3, 8'h0F);
        run(vdpc_pkg::VDPC_CMD_READ, 1'b0, rows[2], cols[2], 8'h00, 8'h00);
        check("masked data", got, (datas[2] & 8'hF0) | 8'h03);
        // block write must not land as a normal store
        run(vdpc_pkg::VDPC_CMD_WRITE, 1'b0, rows[3], cols[3], 8'hAA, 8'h00,
            vdpc_pkg::VDPC_CBR_NO_RESET, 1'b1);
        run(vdpc_pkg::VDPC_CMD_READ, 1'b0, rows[3], cols[3], 8'h00, 8'h00);
        check("block write", got, datas[3]);
        run(vdpc_pkg::VDPC_CMD_READ_XFER, 1'b0, 9'h002, 9'h1A5, 8'h00, 8'h00);
        check("upper half", split_half, 1'b1);
        run(vdpc_pkg::VDPC_CMD_WRITE_XFER, 1'b0, 9'h003, 9'h0A5, 8'h00, 8'h00);
        check("lower half", split_half, 1'b0);
        check("plain transfer", model.split_seen, 1'b0);
        run(vdpc_pkg::VDPC_CMD_READ_XFER, 1'b0, 9'h004, 9'h1A5, 8'h00, 8'h00,
            vdpc_pkg::VDPC_CBR_NO_RESET, 1'b0, 1'b1);
        check("split transfer", model.split_seen, 1'b1);
        n0 = model.cbr_count;
        for (int v = 0; v < 3; v++) begin
            run(vdpc_pkg::VDPC_CMD_CBR_REFRESH, 1'b0, 9'h000, 9'h000, 8'h00, 8'h00,
                vdpc_pkg::vdpc_cbr_t'(2'(v)));
            check("cbr variant", model.cbr_kind, 16'(v));
        end
        check("cbr count", 16'(model.cbr_count - n0), 16'h0003);
        run(vdpc_pkg::VDPC_CMD_RAS_REFRESH, 1'b0, rows[0], 9'h000, 8'h00, 8'h00);
        run(vdpc_pkg::VDPC_CMD_READ, 1'b0, rows[0], cols[0], 8'h00, 8'h00);
        check("data kept", got, datas[0]);
        // reset in the middle of a read: strobes, drive and ready return to idle
        req_valid <= 1'b1;
        repeat (8) @(posedge clk);
        req_valid <= 1'b0;
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        check("reset idle", {pins.ras_n, pins.cas_n, random_data_oe, req_ready}, 4'hD);
        serial_enable_req <= 1'b1;
        repeat (3) @(posedge clk);
        check("serial enable on", pins.serial_port_enable_n, 1'b0);
        serial_enable_req <= 1'b0;
        repeat (3) @(posedge clk);
        check("serial enable off", pins.serial_port_enable_n, 1'b1);
        check("refresh early", refresh_due, 1'b0);
        n0 = 0;
        while (refresh_due !== 1'b1 && n0 < 1400) begin
            @(posedge clk);
            n0++;
        end
        check("refresh due", refresh_due, 1'b1);
        check("bus clash", 16'(model.clash_count), 16'h0000);
        finish_test();
    end
endmodule : vdpc_ctrl_tb
`default_nettype wire
